// >>> hdl/pss_steer.sv
// Overview of operation
// - code 01/10/11 pairs A with B/C/D
// - sync set: apply at period start
// - enable A: pin A carries polarised PWM
// - enable B, code 00: pin B carries polarised PWM
// - with code 00, enables C, D drive own pins likewise
// - steering only with mode 11, config 00
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pss_steer
	import pss_pkg::*;
#(
	parameter int DATA_W = 16
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	input wire logic i_pwm_raw,
	input wire logic i_period_start,
	input wire logic [3:0] i_port_out,
	input wire logic [3:0] i_port_oe,
	output logic o_pwm_out_a,
	output logic o_pwm_out_b,
	output logic o_pwm_out_c,
	output logic o_pwm_out_d,
	output logic [3:0] o_pin_oe
);
	// ****************************************
	// timing references
	// ****************************************
	logic tcy_tick;
	logic period_start_s;
	logic period_start_d_r;
	logic period_edge;
	pss_tcy_tick u_tick (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.o_tick(tcy_tick)
	);
	// period start may come from a timer on another clock; resync it
	pss_sync2 u_psync (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_d(i_period_start),
		.o_q(period_start_s)
	);
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			period_start_d_r <= 1'b0;
		end else begin
			period_start_d_r <= period_start_s;
		end
	end
	assign period_edge = period_start_s & ~period_start_d_r;
	// ****************************************
	// registers
	// ****************************************
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [5:0] cfg_r;
	logic [5:0] cfg_nxt;
	logic [3:0] act_en_r;
	logic [3:0] act_en_nxt;
	logic [1:0] act_cmpl_r;
	logic [1:0] act_cmpl_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [3:0] pin_r;
	logic [3:0] pin_nxt;
	logic [3:0] oe_r;
	logic [3:0] oe_nxt;
	logic apply;
	logic steer_on;
	logic pwm_pol;
	logic [3:0] drive;
	logic [3:0] level;

	function automatic logic [3:0] cmpl_pins(input logic [1:0] code);
		case (code)
			CMPL_B: cmpl_pins = 4'h3;
			CMPL_C: cmpl_pins = 4'h5;
			CMPL_D: cmpl_pins = 4'h9;
			default: cmpl_pins = 4'h0;
		endcase
	endfunction

	// update point chosen by the sync bit
	assign apply = ctrl_r[SYNC_POS] ? period_edge : tcy_tick;

	always_comb begin
		ctrl_nxt = ctrl_r;
		cfg_nxt = cfg_r;
		act_en_nxt = act_en_r;
		act_cmpl_nxt = act_cmpl_r;
		rdata_nxt = '0;
		if (i_wr && i_addr == STEER_CTRL_OFFS) begin
			ctrl_nxt = i_wdata[7:0] & STEER_CTRL_MASK[7:0];
		end
		if (i_wr && i_addr == UNIT_CFG_OFFS) begin
			cfg_nxt = i_wdata[5:0];
		end
		if (apply) begin
			act_en_nxt = ctrl_r[STEER_D_POS:STEER_A_POS];
			act_cmpl_nxt = ctrl_r[CMPL_HI_POS:CMPL_LO_POS];
		end
		if (i_rd) begin
			case (i_addr)
				STEER_CTRL_OFFS: rdata_nxt = DATA_W'(ctrl_r);
				UNIT_CFG_OFFS: rdata_nxt = DATA_W'(cfg_r);
				STATUS_OFFS: rdata_nxt = DATA_W'({steer_on, act_cmpl_r,
					act_en_r});
				default: rdata_nxt = '0;
			endcase
		end
	end

	// ****************************************
	// output steering
	// ****************************************
	assign steer_on = (cfg_r[MODE_HI_HI_POS:MODE_HI_LO_POS] == MODE_UPPER_PWM)
		&& (cfg_r[PM_HI_POS:PM_LO_POS] == PM_SINGLE);
	// polarity bit 0 inverts the active-high level
	assign pwm_pol = i_pwm_raw ^ cfg_r[POL_LO_POS];

	always_comb begin
		drive = '0;
		level = '0;
		if (steer_on) begin
			if (act_cmpl_r == CMPL_NONE) begin
				drive = act_en_r;
				level = {4{pwm_pol}};
			end else begin
				// pair: A takes polarity bit 0, partner is the complement with the second polarity bit
				drive = cmpl_pins(act_cmpl_r);
				level = {{3{~(i_pwm_raw ^ cfg_r[POL_HI_POS])}} & drive[3:1],
					pwm_pol};
			end
		end
		for (int i = 0; i < 4; i++) begin
			pin_nxt[i] = drive[i] ? level[i] : i_port_out[i];
			oe_nxt[i] = drive[i] ? 1'b1 : i_port_oe[i];
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_r <= STEER_CTRL_RESET[7:0];
			cfg_r <= '0;
			act_en_r <= STEER_CTRL_RESET[3:0];
			act_cmpl_r <= '0;
			rdata_r <= '0;
			pin_r <= '0;
			oe_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			cfg_r <= cfg_nxt;
			act_en_r <= act_en_nxt;
			act_cmpl_r <= act_cmpl_nxt;
			rdata_r <= rdata_nxt;
			pin_r <= pin_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_pwm_out_a = pin_r[0];
	assign o_pwm_out_b = pin_r[1];
	assign o_pwm_out_c = pin_r[2];
	assign o_pwm_out_d = pin_r[3];
	assign o_pin_oe = oe_r;

	// ****************************************
	// assertions
	// ****************************************
	property p_off_port;
		@(posedge i_mclk) disable iff (i_sys_rst)
		// sampled reset keeps the release edge, where pins still hold 0, out
		!i_sys_rst && !steer_on |=> o_pwm_out_b == $past(i_port_out[1]);
	endproperty
	a_off_port: assert property (p_off_port)
		else $error("port pin not restored");
	property p_a_pwm;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && act_en_r[0] && act_cmpl_r == CMPL_NONE
		|=> o_pwm_out_a == $past(pwm_pol) && o_pin_oe[0];
	endproperty
	a_a_pwm: assert property (p_a_pwm)
		else $error("pin a not steered");
	property p_b_off;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && !act_en_r[1] && act_cmpl_r == CMPL_NONE
		|=> o_pwm_out_b == $past(i_port_out[1]);
	endproperty
	a_b_off: assert property (p_b_off)
		else $error("pin b not port");
	property p_d_pwm;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && act_en_r[3] && act_cmpl_r == CMPL_NONE
		|=> o_pin_oe[3] && o_pwm_out_d == $past(pwm_pol);
	endproperty
	a_d_pwm: assert property (p_d_pwm)
		else $error("pin d not steered");
	property p_pair_c;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && act_cmpl_r == CMPL_C
		|=> o_pin_oe[2] && o_pwm_out_b == $past(i_port_out[1]);
	endproperty
	a_pair_c: assert property (p_pair_c)
		else $error("pair c wrong");
	property p_sync_hold;
		@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl_r[SYNC_POS] && !period_edge |=> $stable(act_en_r);
	endproperty
	a_sync_hold: assert property (p_sync_hold)
		else $error("update outside period start");
	property p_tcy_apply;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!ctrl_r[SYNC_POS] && tcy_tick |=> act_en_r == $past(ctrl_r[3:0]);
	endproperty
	a_tcy_apply: assert property (p_tcy_apply)
		else $error("update missed on boundary");
	property p_rsvd;
		@(posedge i_mclk) disable iff (i_sys_rst)
		i_rd && i_addr == STEER_CTRL_OFFS |=> o_rdata[15:8] == 8'h00
			&& o_rdata[5] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bits nonzero");
	property p_pair_a;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && act_cmpl_r != CMPL_NONE
		|=> o_pin_oe[0] && o_pwm_out_a == $past(pwm_pol);
	endproperty
	a_pair_a: assert property (p_pair_a)
		else $error("pair pin a wrong");
	property p_pair_b;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && act_cmpl_r == CMPL_B
		|=> o_pin_oe[1]
			&& o_pwm_out_b == ~$past(i_pwm_raw ^ cfg_r[POL_HI_POS]);
	endproperty
	a_pair_b: assert property (p_pair_b)
		else $error("pair b wrong");
	property p_pair_d;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && act_cmpl_r == CMPL_D
		|=> o_pin_oe[3]
			&& o_pwm_out_d == ~$past(i_pwm_raw ^ cfg_r[POL_HI_POS])
			&& o_pwm_out_c == $past(i_port_out[2]);
	endproperty
	a_pair_d: assert property (p_pair_d)
		else $error("pair d wrong");
	property p_b_pwm;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && act_en_r[1] && act_cmpl_r == CMPL_NONE
		|=> o_pin_oe[1] && o_pwm_out_b == $past(pwm_pol);
	endproperty
	a_b_pwm: assert property (p_b_pwm)
		else $error("pin b not steered");
	property p_c_pwm;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && act_en_r[2] && act_cmpl_r == CMPL_NONE
		|=> o_pin_oe[2] && o_pwm_out_c == $past(pwm_pol);
	endproperty
	a_c_pwm: assert property (p_c_pwm)
		else $error("pin c not steered");
	property p_a_off;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && !act_en_r[0] && act_cmpl_r == CMPL_NONE
		|=> o_pwm_out_a == $past(i_port_out[0])
			&& o_pin_oe[0] == $past(i_port_oe[0]);
	endproperty
	a_a_off: assert property (p_a_off)
		else $error("pin a not port");
	property p_d_off;
		@(posedge i_mclk) disable iff (i_sys_rst)
		steer_on && !act_en_r[3] && act_cmpl_r == CMPL_NONE
		|=> o_pwm_out_d == $past(i_port_out[3])
			&& o_pin_oe[3] == $past(i_port_oe[3]);
	endproperty
	a_d_off: assert property (p_d_off)
		else $error("pin d not port");
	property p_off_oe;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!i_sys_rst && !steer_on |=> o_pin_oe == $past(i_port_oe);
	endproperty
	a_off_oe: assert property (p_off_oe)
		else $error("port drive not restored");
	property p_sync_apply;
		@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl_r[SYNC_POS] && period_edge
		|=> act_en_r == $past(ctrl_r[STEER_D_POS:STEER_A_POS]);
	endproperty
	a_sync_apply: assert property (p_sync_apply)
		else $error("update missed at period start");
	property p_tcy_hold;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!ctrl_r[SYNC_POS] && !tcy_tick |=> $stable(act_en_r);
	endproperty
	a_tcy_hold: assert property (p_tcy_hold)
		else $error("update between boundaries");
	c_pair_b: cover property (@(posedge i_mclk) steer_on
		&& act_cmpl_r == CMPL_B);
	c_all_on: cover property (@(posedge i_mclk) steer_on
		&& act_en_r == 4'hf);
	c_sync: cover property (@(posedge i_mclk) ctrl_r[SYNC_POS]
		&& period_edge);
	c_pair_d: cover property (@(posedge i_mclk) steer_on
		&& act_cmpl_r == CMPL_D);
	c_port_back: cover property (@(posedge i_mclk) !steer_on
		&& act_en_r != 4'h0);
endmodule
`default_nettype wire

// >>> hdl/pss_pkg.sv
package pss_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 4;
	localparam logic [3:0] STEER_CTRL_OFFS = 4'h0;
	localparam logic [3:0] UNIT_CFG_OFFS = 4'h4;
	localparam logic [3:0] STATUS_OFFS = 4'h8;
	localparam logic [15:0] STEER_CTRL_RESET = 16'h0001;
	localparam logic [15:0] STEER_CTRL_MASK = 16'h00df;
	localparam logic [15:0] UNIT_CFG_MASK = 16'h003f;
	// ****************************************
	// field positions
	// ****************************************
	localparam int STEER_A_POS = 0;
	localparam int STEER_D_POS = 3;
	localparam int SYNC_POS = 4;
	localparam int CMPL_LO_POS = 6;
	localparam int CMPL_HI_POS = 7;
	localparam int POL_LO_POS = 0;
	localparam int POL_HI_POS = 1;
	localparam int MODE_HI_LO_POS = 2;
	localparam int MODE_HI_HI_POS = 3;
	localparam int PM_LO_POS = 4;
	localparam int PM_HI_POS = 5;
	localparam logic [1:0] MODE_UPPER_PWM = 2'h3;
	localparam logic [1:0] PM_SINGLE = 2'h0;
	localparam logic [1:0] CMPL_NONE = 2'h0;
	localparam logic [1:0] CMPL_B = 2'h1;
	localparam logic [1:0] CMPL_C = 2'h2;
	localparam logic [1:0] CMPL_D = 2'h3;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_NS = 10;
	localparam int TCY_NS = 20;
	localparam int TCY_CYCLES = (TCY_NS + CLK_NS - 1) / CLK_NS;
	localparam int TCY_CNT_W = 4;
endpackage

// >>> hdl/pss_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module pss_sync2 (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_d,
	output logic o_q
);
	logic s1_r;
	logic s2_r;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
		end
	end
	assign o_q = s2_r;
endmodule
`default_nettype wire

// >>> hdl/pss_tcy_tick.sv
`timescale 1ns/1ps
`default_nettype none
module pss_tcy_tick
	import pss_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	output logic o_tick
);
	// instruction-cycle boundary, one pulse per cycle period
	localparam logic [TCY_CNT_W-1:0] LAST = TCY_CNT_W'(TCY_CYCLES - 1);
	logic [TCY_CNT_W-1:0] cnt_r;
	logic [TCY_CNT_W-1:0] cnt_nxt;
	always_comb begin
		cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
	end
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	assign o_tick = (cnt_r == LAST);
endmodule
`default_nettype wire

// >>> test/pss_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
// external loads with pull-downs: an undriven pin reads low
module pss_pin_load (
	input wire logic [3:0] i_lvl,
	input wire logic [3:0] i_oe,
	output logic [3:0] o_pad
);
	assign o_pad = i_lvl & i_oe;
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import pss_pkg::*;
;
	logic i_mclk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_pwm_raw = 1'b0;
	logic i_period_start = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [3:0] i_port_out = 4'ha;
	logic [3:0] i_port_oe = 4'h6;
	logic [15:0] i_wdata = 16'h0000;
	logic [15:0] o_rdata;
	logic pin_a, pin_b, pin_c, pin_d;
	logic [3:0] pin_oe, pad;
	int fail_count = 0;
	int samples_checked = 0;
	logic [15:0] bad [4] = '{16'h0008, 16'h001c, 16'h002c, 16'h0004};

	always #5 i_mclk = ~i_mclk;

	pss_steer pss_steer_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_pwm_raw(i_pwm_raw),
		.i_period_start(i_period_start), .i_port_out(i_port_out),
		.i_port_oe(i_port_oe), .o_pwm_out_a(pin_a), .o_pwm_out_b(pin_b),
		.o_pwm_out_c(pin_c), .o_pwm_out_d(pin_d), .o_pin_oe(pin_oe));
	pss_pin_load pss_pin_load_inst (.i_lvl({pin_d, pin_c, pin_b, pin_a}),
		.i_oe(pin_oe), .o_pad(pad));

	// ****************************************
	// bus and check tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [3:0] a, input logic [15:0] e);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, e);
	endtask

	// pins settle within one instruction tick plus the output register
	task automatic pc(input logic [3:0] en, input logic [3:0] inv);
		logic [3:0] lv, oe;
		repeat (4) @(posedge i_mclk);
		#1;
		oe = en | i_port_oe;
		lv = (en & ({4{i_pwm_raw}} ^ inv)) | (~en & i_port_out);
		chk({8'h00, pin_oe, pad}, {8'h00, oe, lv & oe});
		// hand back on an edge so callers drive inputs there
		@(posedge i_mclk);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (5) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		rdc(STEER_CTRL_OFFS, STEER_CTRL_RESET);
		wr(STEER_CTRL_OFFS, 16'hffff);
		rdc(STEER_CTRL_OFFS, STEER_CTRL_MASK);
		wr(UNIT_CFG_OFFS, 16'hffff);
		rdc(UNIT_CFG_OFFS, UNIT_CFG_MASK);
		rdc(4'hc, 16'h0000);
		$display("test registers done");
		wr(STEER_CTRL_OFFS, 16'h000f);
		foreach (bad[i]) begin
			wr(UNIT_CFG_OFFS, bad[i]);
			pc(4'h0, 4'h0);
		end
		$display("test mode gating done");
		wr(UNIT_CFG_OFFS, 16'h000c);
		for (int p = 0; p < 2; p++) begin
			i_pwm_raw <= p[0];
			pc(4'hf, 4'h0);
		end
		wr(UNIT_CFG_OFFS, 16'h000d);
		pc(4'hf, 4'hf);
		wr(STEER_CTRL_OFFS, 16'h000a);
		pc(4'ha, 4'ha);
		i_port_out <= 4'h5;
		pc(4'ha, 4'ha);
		$display("test single steering done");
		wr(UNIT_CFG_OFFS, 16'h000c);
		for (int c = 1; c < 4; c++) begin
			wr(STEER_CTRL_OFFS, 16'(c << CMPL_LO_POS));
			pc(4'h1 | (4'h1 << c), 4'h1 << c);
			rdc(STATUS_OFFS, 16'h0040 | 16'(c << 4));
		end
		wr(UNIT_CFG_OFFS, 16'h000f);
		pc(4'h9, 4'h1);
		$display("test pairs done");
		wr(STEER_CTRL_OFFS, 16'h0000);
		pc(4'h0, 4'h0);
		wr(STEER_CTRL_OFFS, 16'h0015);
		repeat (8) @(posedge i_mclk);
		pc(4'h0, 4'h0);
		i_period_start <= 1'b1;
		repeat (2) @(posedge i_mclk);
		pc(4'h5, 4'h5);
		i_period_start <= 1'b0;
		$display("test period sync done");
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		rdc(STEER_CTRL_OFFS, STEER_CTRL_RESET);
		rdc(UNIT_CFG_OFFS, 16'h0000);
		pc(4'h0, 4'h0);
		$display("test mid-run reset done");
		finish_test();
	end

	// whole run is about 150 cycles; this is ample
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
endmodule
`default_nettype wire
